/* verilog/flash_regs_pkg.sv */
// constants, instruction codes and state types of the status register bank
// assumes a 10 MHz system clock and a serial link sampled by that clock
package flash_regs_pkg;
   // instruction codes
   localparam logic [7:0] OP_WRSR1 = 8'h01;
   localparam logic [7:0] OP_WRSR2 = 8'h31;
   localparam logic [7:0] OP_WRSR3 = 8'h11;
   localparam logic [7:0] OP_RDSR1 = 8'h05;
   localparam logic [7:0] OP_RDSR2 = 8'h35;
   localparam logic [7:0] OP_RDSR3 = 8'h15;
   localparam logic [7:0] OP_WREN = 8'h06;
   localparam logic [7:0] OP_WRDI = 8'h04;
   localparam logic [7:0] OP_PP = 8'h02;
   localparam logic [7:0] OP_QPP = 8'h32;
   localparam logic [7:0] OP_SE = 8'h20;
   localparam logic [7:0] OP_BE32 = 8'h52;
   localparam logic [7:0] OP_BE64 = 8'hd8;
   localparam logic [7:0] OP_CE1 = 8'hc7;
   localparam logic [7:0] OP_CE2 = 8'h60;
   localparam logic [7:0] OP_SECERASE = 8'h44;
   localparam logic [7:0] OP_SECPROG = 8'h42;
   localparam logic [7:0] OP_SUSPEND = 8'h75;
   localparam logic [7:0] OP_RESUME = 8'h7a;
   localparam logic [7:0] OP_BLKLOCK = 8'h36;
   localparam logic [7:0] OP_BLKUNLOCK = 8'h39;
   // field positions inside each status byte
   localparam int BP_LO = 2;
   localparam int TB_POS = 5;
   localparam int SEC_POS = 6;
   localparam int SRL_POS = 0;
   localparam int LB_LO = 3;
   localparam int CMP_POS = 6;
   localparam int WPS_POS = 2;
   localparam int DRV_LO = 5;
   // values after reset
   localparam logic [2:0] BP_RST = 3'h0;
   localparam logic QE_RST = 1'b1;
   localparam logic [1:0] DRV_RST = 2'h3;
   localparam logic [127:0] BLOCK_LOCK_RST = '1;
   // erase spans as address masks
   localparam logic [22:0] SPAN_4K = 23'h000fff;
   localparam logic [22:0] SPAN_32K = 23'h007fff;
   localparam logic [22:0] SPAN_64K = 23'h00ffff;
   localparam logic [22:0] SPAN_ALL = 23'h7fffff;
   // busy durations
   localparam int CLK_PERIOD_NS = 100;
   localparam int WRSR_TIME_NS = 5000;
   localparam int PROG_TIME_NS = 20000;
   localparam int ERASE_TIME_NS = 300000;
   localparam logic [11:0] WRSR_CYCLES = 12'((WRSR_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [11:0] PROG_CYCLES = 12'((PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [11:0] ERASE_CYCLES = 12'((ERASE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   typedef enum logic [1:0] {ST_IDLE, ST_BUSY, ST_SUSPEND} busyState_type;
endpackage

/* verilog/spi_byte_if.sv */
// byte-level link between the serial shifter and the register core
// assumes both ends run on clk_sys
`timescale 1ns/1ps
interface spi_byte_if;
   logic byteDone;
   logic [7:0] rxByte;
   logic [7:0] txByte;
   logic frameEnd;
   logic frameOn;
   modport shifter(output byteDone, rxByte, frameEnd, frameOn, input txByte);
   modport core(input byteDone, rxByte, frameEnd, frameOn, output txByte);
endinterface

/* verilog/pin_sync.sv */
// three-stage synchroniser; output moves once stages two and three agree
// assumes pins are asynchronous to clk_sys
`timescale 1ns/1ps
module pin_sync #(
   parameter int W = 3,
   parameter logic [W-1:0] INIT = '0
) (
   // clock and reset
   input wire logic clk_sys,
   input wire logic reset_n,
   // pins in, settled levels out
   input wire logic [W-1:0] pinRaw,
   output logic [W-1:0] pinLevel
);
   genvar i;
   generate
      for (i = 0; i < W; i++) begin : g_bit
         logic [2:0] stage_r;
         logic level_r;
         always_ff @(posedge clk_sys) begin
            if (!reset_n) begin
               stage_r <= {3{INIT[i]}};
               level_r <= INIT[i];
            end else begin
               stage_r <= {stage_r[1:0], pinRaw[i]};
               if (stage_r[1] == stage_r[2]) begin
                  level_r <= stage_r[2];
               end
            end
         end
         assign pinLevel[i] = level_r;
      end
   endgenerate
endmodule

/* verilog/spi_frame_shift.sv */
// serial shifter: bytes in msb first on sck rise, out on sck fall
// assumes settled pin levels; spi modes 0 and 3
`timescale 1ns/1ps
module spi_frame_shift (
   // clock and reset
   input wire logic clk_sys,
   input wire logic reset_n,
   // settled link levels
   input wire logic csN,
   input wire logic sck,
   input wire logic di,
   // serial output pad
   output logic sdo,
   output logic sdoOe,
   // byte side
   spi_byte_if.shifter bus
);
   logic sckPrev_r;
   logic csPrev_r;
   logic [2:0] bitCnt_r;
   logic [7:0] rxShift_r;
   logic [7:0] txShift_r;
   logic loadDue_r;
   logic byteDone_r;
   logic frameEnd_r;
   logic sckRise;
   logic sckFall;
   assign sckRise = !csN && sck && !sckPrev_r;
   assign sckFall = !csN && !sck && sckPrev_r;
   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         sckPrev_r <= 1'b0;
         csPrev_r <= 1'b1;
         bitCnt_r <= 3'h0;
         rxShift_r <= 8'h00;
         txShift_r <= 8'h00;
         loadDue_r <= 1'b0;
         byteDone_r <= 1'b0;
         frameEnd_r <= 1'b0;
         sdoOe <= 1'b0;
      end else begin
         sckPrev_r <= sck;
         csPrev_r <= csN;
         byteDone_r <= sckRise && bitCnt_r == 3'h7;
         frameEnd_r <= csN && !csPrev_r;
         if (csN) begin
            bitCnt_r <= 3'h0;
            loadDue_r <= 1'b0;
            sdoOe <= 1'b0;
         end else if (sckRise) begin
            rxShift_r <= {rxShift_r[6:0], di};
            bitCnt_r <= bitCnt_r + 3'h1;
            loadDue_r <= loadDue_r || bitCnt_r == 3'h7;
         end else if (sckFall && loadDue_r) begin
            txShift_r <= bus.txByte;
            loadDue_r <= 1'b0;
            sdoOe <= 1'b1;
         end else if (sckFall) begin
            txShift_r <= {txShift_r[6:0], 1'b0};
         end
      end
   end
   assign sdo = txShift_r[7];
   assign bus.byteDone = byteDone_r;
   assign bus.rxByte = rxShift_r;
   assign bus.frameEnd = frameEnd_r;
   assign bus.frameOn = !csN;
endmodule

/* verilog/flash_status_config_regs.sv */
// status and configuration register bank of a serial nor flash
// assumes an spi host on the pins; the array engines sit elsewhere
`timescale 1ns/1ps
module flash_status_config_regs (
   // clock and reset
   input wire logic clk_sys,
   input wire logic reset_n,
   // serial link pins
   input wire logic spiCsN,
   input wire logic spiSck,
   input wire logic spiDi,
   output logic spiDo,
   output logic spiDoOe,
   // settings seen by the array and pads
   output logic [1:0] driveStrength,
   output logic quadEnable,
   output logic protectScheme,
   output logic deviceBusy
);
   logic [2:0] pinLevel;
   spi_byte_if link();

   pin_sync #(.W(3), .INIT(3'b001)) u_sync (
      .clk_sys(clk_sys),
      .reset_n(reset_n),
      .pinRaw({spiDi, spiSck, spiCsN}),
      .pinLevel(pinLevel)
   );

   spi_frame_shift u_shift (
      .clk_sys(clk_sys),
      .reset_n(reset_n),
      .csN(pinLevel[0]),
      .sck(pinLevel[1]),
      .di(pinLevel[2]),
      .sdo(spiDo),
      .sdoOe(spiDoOe),
      .bus(link)
   );

   // frame capture
   logic [7:0] opcode_r;
   logic [2:0] byteCnt_r;
   logic [23:0] addr_r;
   logic [7:0] data_r;
   // status and configuration bits
   logic writeEnableLatch_r;
   logic [2:0] protectLevel_r;
   logic topBottomSelect_r;
   logic sectorGranularity_r;
   logic complementProtect_r;
   logic statusLock_r;
   logic suspendFlag_r;
   logic [2:0] securityLock_r;
   logic quadIoEnable_r;
   logic protectSchemeSelect_r;
   logic [1:0] driveStrength_r;
   logic [127:0] blockLock_r;
   // operation sequencer
   flash_regs_pkg::busyState_type state_r;
   flash_regs_pkg::busyState_type stateNxt;
   logic [11:0] busyCnt_r;
   logic [11:0] busyCntNxt;
   logic wrsrRun_r;
   logic deviceBusy_r;

   // one address spot against the status-bit protection scheme
   function automatic logic spotProtected(input logic [6:0] blk, input logic [3:0] sec,
         input logic [2:0] bp, input logic tb, input logic sg, input logic cmp);
      logic hit;
      logic [7:0] span;
      logic [3:0] secSpan;
      hit = 1'b0;
      span = 8'h01 << bp;
      secSpan = 4'h1 << (bp[2] ? 3'h3 : bp - 3'h1);
      if (bp == 3'h7) begin
         hit = 1'b1;
      end else if (bp != 3'h0 && !sg) begin
         // whole 64KB blocks from one end
         hit = tb ? ({1'b0, blk} < span) : ({1'b0, blk} >= 8'h80 - span);
      end else if (bp != 3'h0) begin
         // 4KB sectors inside the end block
         hit = tb ? (blk == 7'h00 && sec < secSpan)
                  : (blk == 7'h7f && {1'b0, sec} >= 5'h10 - {1'b0, secSpan});
      end
      // swap protected and open areas
      return hit ^ cmp;
   endfunction

   // command decode
   logic fe;
   logic isIdle;
   logic opOnly;
   logic wrsrLen;
   logic addrLen;
   logic progLen;
   logic isWrsr;
   logic isChip;
   logic isErase;
   logic isProg;
   logic isSecOp;
   assign fe = link.frameEnd;
   assign isIdle = state_r == flash_regs_pkg::ST_IDLE;
   assign opOnly = byteCnt_r == 3'h1;
   assign wrsrLen = byteCnt_r == 3'h2;
   assign addrLen = byteCnt_r == 3'h4;
   assign progLen = byteCnt_r >= 3'h5;
   assign isWrsr = opcode_r == flash_regs_pkg::OP_WRSR1 || opcode_r == flash_regs_pkg::OP_WRSR2
                   || opcode_r == flash_regs_pkg::OP_WRSR3;
   assign isChip = opcode_r == flash_regs_pkg::OP_CE1 || opcode_r == flash_regs_pkg::OP_CE2;
   assign isErase = isChip || opcode_r == flash_regs_pkg::OP_SE || opcode_r == flash_regs_pkg::OP_BE32
                    || opcode_r == flash_regs_pkg::OP_BE64 || opcode_r == flash_regs_pkg::OP_SECERASE;
   assign isProg = opcode_r == flash_regs_pkg::OP_PP || opcode_r == flash_regs_pkg::OP_QPP
                   || opcode_r == flash_regs_pkg::OP_SECPROG;
   assign isSecOp = opcode_r == flash_regs_pkg::OP_SECERASE || opcode_r == flash_regs_pkg::OP_SECPROG;

   // target region of an erase or program
   logic [22:0] spanMask;
   logic [22:0] startA;
   logic [22:0] endA;
   logic startHit;
   logic endHit;
   logic arrayHit;
   logic [1:0] secIdx;
   logic secHit;
   logic targetBlocked;
   assign spanMask = isChip ? flash_regs_pkg::SPAN_ALL
                   : opcode_r == flash_regs_pkg::OP_SE ? flash_regs_pkg::SPAN_4K
                   : opcode_r == flash_regs_pkg::OP_BE32 ? flash_regs_pkg::SPAN_32K
                   : opcode_r == flash_regs_pkg::OP_BE64 ? flash_regs_pkg::SPAN_64K : 23'h000000;
   assign startA = isChip ? 23'h000000 : addr_r[22:0];
   assign endA = startA | spanMask;
   assign startHit = spotProtected(startA[22:16], startA[15:12], protectLevel_r,
                                   topBottomSelect_r, sectorGranularity_r, complementProtect_r);
   assign endHit = spotProtected(endA[22:16], endA[15:12], protectLevel_r,
                                 topBottomSelect_r, sectorGranularity_r, complementProtect_r);
   // scheme choice: status bits or per-block locks
   assign arrayHit = protectSchemeSelect_r
                     ? (isChip ? |blockLock_r : blockLock_r[startA[22:16]] | blockLock_r[endA[22:16]])
                     : startHit | endHit;
   assign secIdx = addr_r[13:12] - 2'h1;
   // a locked security register is read-only
   assign secHit = addr_r[13:12] == 2'h0 || securityLock_r[secIdx];
   assign targetBlocked = isSecOp ? secHit : arrayHit;

   // accepted actions, each a one-cycle pulse at frame end
   logic doWren;
   logic doWrdi;
   logic doWrsr;
   logic doErase;
   logic doProg;
   logic doJob;
   logic doSuspend;
   logic doResume;
   logic doLockBlk;
   logic doUnlockBlk;
   logic wr1;
   logic wr2;
   logic wr3;
   // everything but suspend and resume waits for idle
   assign doWren = fe && isIdle && opOnly && opcode_r == flash_regs_pkg::OP_WREN;
   assign doWrdi = fe && isIdle && opOnly && opcode_r == flash_regs_pkg::OP_WRDI;
   assign doWrsr = fe && isIdle && wrsrLen && isWrsr && writeEnableLatch_r && !statusLock_r;
   assign doErase = fe && isIdle && isErase && (isChip ? opOnly : addrLen)
                    && writeEnableLatch_r && !targetBlocked;
   assign doProg = fe && isIdle && isProg && progLen && writeEnableLatch_r && !targetBlocked;
   assign doJob = doWrsr || doErase || doProg;
   assign doSuspend = fe && state_r == flash_regs_pkg::ST_BUSY && !wrsrRun_r && opOnly
                      && opcode_r == flash_regs_pkg::OP_SUSPEND;
   assign doResume = fe && state_r == flash_regs_pkg::ST_SUSPEND && opOnly
                     && opcode_r == flash_regs_pkg::OP_RESUME;
   assign doLockBlk = fe && isIdle && addrLen && opcode_r == flash_regs_pkg::OP_BLKLOCK;
   assign doUnlockBlk = fe && isIdle && addrLen && opcode_r == flash_regs_pkg::OP_BLKUNLOCK;
   assign wr1 = doWrsr && opcode_r == flash_regs_pkg::OP_WRSR1;
   assign wr2 = doWrsr && opcode_r == flash_regs_pkg::OP_WRSR2;
   assign wr3 = doWrsr && opcode_r == flash_regs_pkg::OP_WRSR3;

   // status bytes; unused positions read zero
   logic [7:0] statusOne;
   logic [7:0] statusTwo;
   logic [7:0] statusThree;
   assign statusOne = {1'b0, sectorGranularity_r, topBottomSelect_r, protectLevel_r,
                       writeEnableLatch_r, deviceBusy_r};
   assign statusTwo = {suspendFlag_r, complementProtect_r, securityLock_r, 1'b0,
                       quadIoEnable_r, statusLock_r};
   assign statusThree = {1'b0, driveStrength_r, 2'b00, protectSchemeSelect_r, 2'b00};
   assign link.txByte = opcode_r == flash_regs_pkg::OP_RDSR1 ? statusOne
                      : opcode_r == flash_regs_pkg::OP_RDSR2 ? statusTwo
                      : opcode_r == flash_regs_pkg::OP_RDSR3 ? statusThree : 8'h00;

   // frame capture
   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         opcode_r <= 8'h00;
         byteCnt_r <= 3'h0;
         addr_r <= 24'h000000;
         data_r <= 8'h00;
      end else if (fe) begin
         byteCnt_r <= 3'h0;
      end else if (link.byteDone) begin
         byteCnt_r <= byteCnt_r == 3'h7 ? byteCnt_r : byteCnt_r + 3'h1;
         if (byteCnt_r == 3'h0) begin
            opcode_r <= link.rxByte;
         end
         if (byteCnt_r == 3'h1) begin
            data_r <= link.rxByte;
         end
         if (byteCnt_r >= 3'h1 && byteCnt_r <= 3'h3) begin
            addr_r <= {addr_r[15:0], link.rxByte};
         end
      end
   end

   // busy sequencer
   always_comb begin
      stateNxt = state_r;
      busyCntNxt = busyCnt_r;
      case (state_r)
         flash_regs_pkg::ST_IDLE: begin
            if (doJob) begin
               stateNxt = flash_regs_pkg::ST_BUSY;
               busyCntNxt = doWrsr ? flash_regs_pkg::WRSR_CYCLES
                          : doProg ? flash_regs_pkg::PROG_CYCLES : flash_regs_pkg::ERASE_CYCLES;
            end
         end
         flash_regs_pkg::ST_BUSY: begin
            if (doSuspend) begin
               stateNxt = flash_regs_pkg::ST_SUSPEND;
            end else if (busyCnt_r == 12'h001) begin
               stateNxt = flash_regs_pkg::ST_IDLE;
            end else begin
               busyCntNxt = busyCnt_r - 12'h001;
            end
         end
         flash_regs_pkg::ST_SUSPEND: begin
            if (doResume) begin
               stateNxt = flash_regs_pkg::ST_BUSY;
            end
         end
         default: begin
            stateNxt = flash_regs_pkg::ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         state_r <= flash_regs_pkg::ST_IDLE;
         busyCnt_r <= 12'h000;
         wrsrRun_r <= 1'b0;
         deviceBusy_r <= 1'b0;
      end else begin
         state_r <= stateNxt;
         busyCnt_r <= busyCntNxt;
         wrsrRun_r <= doJob ? doWrsr : wrsrRun_r;
         deviceBusy_r <= stateNxt == flash_regs_pkg::ST_BUSY;
      end
   end

   // write enable latch
   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         writeEnableLatch_r <= 1'b0;
      end else if (doWren) begin
         writeEnableLatch_r <= 1'b1;
      end else if (doWrdi || doJob) begin
         writeEnableLatch_r <= 1'b0;
      end
   end

   // configuration bits, reset to factory values
   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         protectLevel_r <= flash_regs_pkg::BP_RST;
         topBottomSelect_r <= 1'b0;
         sectorGranularity_r <= 1'b0;
         complementProtect_r <= 1'b0;
         statusLock_r <= 1'b0;
         securityLock_r <= 3'h0;
         quadIoEnable_r <= flash_regs_pkg::QE_RST;
         protectSchemeSelect_r <= 1'b0;
         driveStrength_r <= flash_regs_pkg::DRV_RST;
      end else begin
         if (wr1) begin
            protectLevel_r <= data_r[flash_regs_pkg::BP_LO +: 3];
            topBottomSelect_r <= data_r[flash_regs_pkg::TB_POS];
            sectorGranularity_r <= data_r[flash_regs_pkg::SEC_POS];
         end
         if (wr2) begin
            // lock once set holds until reset
            statusLock_r <= data_r[flash_regs_pkg::SRL_POS];
            // locks only ever set
            securityLock_r <= securityLock_r | data_r[flash_regs_pkg::LB_LO +: 3];
            complementProtect_r <= data_r[flash_regs_pkg::CMP_POS];
         end
         // quad enable keeps its reset value of one
         quadIoEnable_r <= quadIoEnable_r;
         if (wr3) begin
            protectSchemeSelect_r <= data_r[flash_regs_pkg::WPS_POS];
            driveStrength_r <= data_r[flash_regs_pkg::DRV_LO +: 2];
         end
      end
   end

   // suspend flag and block locks
   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         suspendFlag_r <= 1'b0;
         blockLock_r <= flash_regs_pkg::BLOCK_LOCK_RST;
      end else begin
         if (doSuspend) begin
            suspendFlag_r <= 1'b1;
         end else if (doResume) begin
            suspendFlag_r <= 1'b0;
         end
         if (doLockBlk) begin
            blockLock_r[addr_r[22:16]] <= 1'b1;
         end else if (doUnlockBlk) begin
            blockLock_r[addr_r[22:16]] <= 1'b0;
         end
      end
   end

   assign driveStrength = driveStrength_r;
   assign quadEnable = quadIoEnable_r;
   assign protectScheme = protectSchemeSelect_r;
   assign deviceBusy = deviceBusy_r;
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!reset_n);

   sequence jobStart;
      doJob;
   endsequence
   sequence busyHeld;
      ##1 deviceBusy_r [*2];
   endsequence

   busy_launch_a:
   assert property (jobStart |-> busyHeld) else $error("busy not raised for new job");
   busy_ignore_a:
   assert property (deviceBusy_r |-> !(doJob || doWren || doWrdi || doLockBlk))
      else $error("command taken while busy");
   busy_end_a:
   assert property ((state_r == flash_regs_pkg::ST_BUSY && busyCnt_r == 12'h001 && !doSuspend)
      |=> !deviceBusy_r && isIdle) else $error("busy not cleared at completion");
   wel_set_a:
   assert property (doWren |=> writeEnableLatch_r) else $error("latch not set");
   wel_clear_a:
   assert property ((doWrdi || doJob) |=> !writeEnableLatch_r) else $error("latch not cleared");
   lock_hold_a:
   assert property (statusLock_r |=> statusLock_r && $stable(protectLevel_r)
      && $stable(complementProtect_r) && $stable(driveStrength_r))
      else $error("status changed while locked");
   suspend_flag_a:
   assert property (doSuspend |=> suspendFlag_r && !deviceBusy_r ##0 !doResume [*1])
      else $error("suspend not reported");
   otp_keep_a:
   assert property (($past(securityLock_r) & ~securityLock_r) == 3'h0)
      else $error("security lock cleared");
   quad_fixed_a:
   assert property (quadEnable) else $error("quad enable dropped");
   lock_reset_a:
   assert property ($rose(reset_n) |-> &blockLock_r) else $error("block locks not set");
   wrsr_gate_a:
   assert property ((fe && isWrsr && (!writeEnableLatch_r || statusLock_r))
      |=> $stable(statusThree) && $stable(protectLevel_r) && $stable(complementProtect_r))
      else $error("status write without permission");
   protect_refuse_a:
   assert property ((fe && isIdle && (isErase || isProg) && targetBlocked) |=> !deviceBusy_r)
      else $error("protected region modified");
   wel_needed_a:
   assert property ((fe && isIdle && !writeEnableLatch_r) |=> !deviceBusy_r)
      else $error("job started without latch");
endmodule

/* sim/spi_host_model.sv */
// spi host model: mode 0 frames, msb first, 800 ns link clock
// assumes the device samples on sck rise and shifts out on sck fall
`timescale 1ns/1ps
module spi_host_model (
   // serial link
   output logic spiCsN,
   output logic spiSck,
   output logic spiDi,
   input wire logic spiDo
);
   initial begin
      spiCsN = 1'b1;
      spiSck = 1'b0;
      spiDi = 1'b0;
   end
   // sends nb bytes from the top of tx; rx gets the last byte read back
   task automatic frame(input int nb, input logic [31:0] tx, output logic [7:0] rx);
      int i;
      #13 spiCsN = 1'b0;
      for (i = 31; i >= 32 - 8 * nb; i--) begin
         spiDi = tx[i];
         #400 spiSck = 1'b1;
         #400 rx = {rx[6:0], spiDo};
         spiSck = 1'b0;
      end
      #400 spiCsN = 1'b1;
      // released data line shows the inverse, not the last value
      spiDi = ~spiDi;
      #800;
   endtask
endmodule

/* sim/tb_flash_status_config_regs.sv */
// testbench of the status register bank
// assumes the spi host model drives the link pins
`timescale 1ns/1ps
module tb_flash_status_config_regs;
   logic clk_sys = 1'b0;
   logic reset_n = 1'b0;
   wire spiCsN, spiSck, spiDi, spiDo;
   logic [1:0] driveStrength;
   logic quadEnable, protectScheme, deviceBusy, spiDoOe;
   int oeCycles = 0;
   int failures = 0;
   int checks_done = 0;
   logic [7:0] rx;
   flash_status_config_regs uut (.clk_sys(clk_sys), .reset_n(reset_n), .spiCsN(spiCsN),
      .spiSck(spiSck), .spiDi(spiDi), .spiDo(spiDo), .spiDoOe(spiDoOe),
      .driveStrength(driveStrength),
      .quadEnable(quadEnable), .protectScheme(protectScheme), .deviceBusy(deviceBusy));
   spi_host_model host (.spiCsN(spiCsN), .spiSck(spiSck), .spiDi(spiDi), .spiDo(spiDo));
   initial begin
      forever #50 clk_sys = ~clk_sys;
   end
   // counts clocks with the data output enabled
   always @(posedge clk_sys) begin
      if (spiDoOe === 1'b1) begin
         oeCycles <= oeCycles + 1;
      end
   end
   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      checks_done++;
      if (got !== exp) begin
         failures++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic stop_test;
      $display("checks %0d failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   task automatic cmd(input int nb, input logic [31:0] tx);
      host.frame(nb, tx, rx);
   endtask
   task automatic rd(input logic [7:0] op, input logic [7:0] exp);
      int oeStart;
      oeStart = oeCycles;
      host.frame(2, {op, 24'h0}, rx);
      chk("status", exp, rx);
      // enable stands for the whole answer byte, about 68 clocks
      chk("output enable", 8'h01, {7'h0, oeCycles > oeStart + 40});
   endtask
   // packs output enable, busy, quad, scheme and drive pins into one byte
   task automatic pins(input logic [7:0] exp);
      chk("pins", exp, {2'h0, spiDoOe, deviceBusy, quadEnable, protectScheme, driveStrength});
   endtask
   task automatic settle;
      int n;
      n = 0;
      while (deviceBusy !== 1'b0 && n < 4000) begin
         @(posedge clk_sys);
         #1;
         n++;
      end
      chk("idle", 8'h00, {7'h0, deviceBusy});
   endtask
   task automatic wr(input logic [7:0] op, input logic [7:0] d);
      host.frame(1, 32'h06000000, rx);
      host.frame(2, {op, d, 16'h0}, rx);
      settle();
   endtask
   initial begin
      repeat (20) @(posedge clk_sys);
      #1 reset_n = 1'b1;
      pins(8'h0b);
      rd(8'h05, 8'h00);
      rd(8'h35, 8'h02);
      rd(8'h15, 8'h60);
      cmd(2, 32'h11040000);
      rd(8'h15, 8'h60);
      cmd(1, 32'h06000000);
      rd(8'h05, 8'h02);
      cmd(1, 32'h04000000);
      rd(8'h05, 8'h00);
      cmd(1, 32'h06000000);
      cmd(4, 32'h20000000);
      pins(8'h1b);
      cmd(1, 32'h06000000);
      cmd(1, 32'h75000000);
      rd(8'h35, 8'h82);
      pins(8'h0b);
      cmd(1, 32'h7a000000);
      pins(8'h1b);
      settle();
      rd(8'h05, 8'h00);
      wr(8'h11, 8'h9f);
      pins(8'h0c);
      rd(8'h15, 8'h04);
      rd(8'h05, 8'h00);
      wr(8'h01, 8'h3c);
      rd(8'h05, 8'h3c);
      cmd(1, 32'h06000000);
      cmd(4, 32'h20000000);
      pins(8'h0c);
      rd(8'h05, 8'h3e);
      cmd(4, 32'h39000000);
      cmd(4, 32'h20000000);
      pins(8'h1c);
      settle();
      wr(8'h11, 8'h00);
      pins(8'h08);
      cmd(1, 32'h06000000);
      cmd(4, 32'h20000000);
      pins(8'h08);
      rd(8'h05, 8'h3e);
      wr(8'h31, 8'h40);
      rd(8'h35, 8'h42);
      cmd(1, 32'h06000000);
      cmd(4, 32'h20000000);
      pins(8'h18);
      settle();
      wr(8'h31, 8'h39);
      rd(8'h35, 8'h3b);
      wr(8'h11, 8'h60);
      pins(8'h08);
      stop_test();
   end
   // the sequence needs about 1 ms; 4 ms means a hang
   initial begin
      #4000000;
      failures++;
      stop_test();
   end
endmodule
